// ===== rpio_cmd_model.sv
// Command processor model that takes self-launched commands after a stall
`timescale 1ns/1ps
`default_nettype none
module rpio_cmd_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire rpio_pkg::rpio_cmd_t launch,
   input wire logic [3:0] stall,
   output logic cmd_ready,
   output logic [2:0] last_slot,
   output logic [31:0] last_word,
   output logic [7:0] taken
);
   logic [3:0] wait_ff;

   // Ready pulses once per command after the stall, so a held launch is exercised
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_ready <= 1'b0;
         wait_ff <= 4'h0;
         taken <= 8'h00;
         last_slot <= 3'h7;
         last_word <= 32'h0000_0000;
      end else if (launch.valid && cmd_ready) begin
         cmd_ready <= 1'b0;
         wait_ff <= 4'h0;
         last_slot <= launch.slot;
         last_word <= launch.word;
         taken <= taken + 8'h01;
      end else if (launch.valid) begin
         cmd_ready <= (wait_ff >= stall);
         wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule // rpio_cmd_model
`default_nettype wire

// ===== rpio_core.sv
// Programmable digital I/O and self-operation logic with Wishbone registers
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rpio_core #(
   parameter int unsigned TICK_CYCLES = rpio_pkg::TICK_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [rpio_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq,
   input wire logic [rpio_pkg::N_IO-1:0] din,
   output logic [rpio_pkg::N_IO-1:0] dout,
   input wire logic run_state,
   input wire logic fault_stop,
   input wire logic [rpio_pkg::N_IO-1:0] antenna_select_indicators,
   input wire logic net_connect,
   input wire rpio_pkg::rpio_resp_t resp,
   input wire logic cmd_ready,
   output rpio_pkg::rpio_cmd_t launch
);
   localparam int unsigned N = rpio_pkg::N_IO;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // Byte-lane merge for register writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction

   // Register state
   logic [N-1:0] in_mode_ff;
   logic [2*N-1:0] out_mode_ff;
   logic [N-1:0] out_host_ff;
   logic [3*N-1:0] out_src_ff;
   logic [rpio_pkg::IRQ_W-1:0] stat_ff;
   logic [rpio_pkg::IRQ_W-1:0] mask_ff;
   logic [31:0] slot_mem [rpio_pkg::N_SLOT];
   logic [31:0] jn_cfg_ff [N];
   logic [31:0] jdur_ff [N];
   logic [31:0] je_cfg_ff [N];
   logic [31:0] jdata_ff [N];
   logic [15:0] jn_cnt_ff [N];
   logic [15:0] je_cnt_ff [N];
   logic ack_ff;
   logic [31:0] dat_ff;
   logic irq_ff;
   logic [N-1:0] dout_ff;
   rpio_pkg::rpio_cmd_t launch_ff;
   logic [rpio_pkg::N_SLOT-1:0] pend_ff;
   logic [N-1:0] sync1_ff;
   logic [N-1:0] sync2_ff;
   logic [N-1:0] sync3_ff;
   logic [31:0] tick_cnt_ff;

   // Bus decode; one write per request since ack drops the strobe window
   wire bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
   wire wr = bus_req && wb_we_i;
   wire [31:0] wdat_in_mode = lane_merge({28'h0, in_mode_ff}, wb_dat_i, wb_sel_i);
   wire [31:0] wdat_out_mode = lane_merge({24'h0, out_mode_ff}, wb_dat_i, wb_sel_i);
   wire [31:0] wdat_out_host = lane_merge({28'h0, out_host_ff}, wb_dat_i, wb_sel_i);
   wire [31:0] wdat_out_src = lane_merge({20'h0, out_src_ff}, wb_dat_i, wb_sel_i);
   wire [31:0] wdat_mask = lane_merge({26'h0, mask_ff}, wb_dat_i, wb_sel_i);
   localparam logic [31:0] ZERO_W = rpio_pkg::ZERO32;
   // Write-one-clear merges onto zero, so only written ones clear
   wire [31:0] wdat_w1c = lane_merge(ZERO_W, wb_dat_i, wb_sel_i);
   wire hit_in_mode = wb_adr_i == rpio_pkg::ADR_IN_MODE;
   wire hit_out_mode = wb_adr_i == rpio_pkg::ADR_OUT_MODE;
   wire hit_out_host = wb_adr_i == rpio_pkg::ADR_OUT_HOST;
   wire hit_out_src = wb_adr_i == rpio_pkg::ADR_OUT_SRC;
   wire hit_level = wb_adr_i == rpio_pkg::ADR_IN_LEVEL;
   wire hit_stat = wb_adr_i == rpio_pkg::ADR_IRQ_STAT;
   wire hit_mask = wb_adr_i == rpio_pkg::ADR_IRQ_MASK;
   wire [2:0] slot_idx = wb_adr_i[4:2];
   wire hit_slot = (wb_adr_i[7:5] == rpio_pkg::SLOT_PAGE) && (slot_idx < 3'(rpio_pkg::N_SLOT));
   wire hit_judg = wb_adr_i[7:6] == rpio_pkg::JUDG_PAGE;
   wire [1:0] j_out = wb_adr_i[5:4];
   wire [1:0] j_word = wb_adr_i[3:2];

   // Level query shows only inputs set to level mode
   wire [N-1:0] level_rd = sync2_ff & ~in_mode_ff;

   // Judgment window read select
   wire [31:0] judg_rd = (j_word == rpio_pkg::JW_NORM) ? jn_cfg_ff[j_out] :
                         (j_word == rpio_pkg::JW_DUR) ? jdur_ff[j_out] :
                         (j_word == rpio_pkg::JW_ERR) ? je_cfg_ff[j_out] : jdata_ff[j_out];

   // Read mux; unmapped addresses answer zero
   wire [31:0] rd_mux = hit_in_mode ? {28'h0, in_mode_ff} :
                        hit_out_mode ? {24'h0, out_mode_ff} :
                        hit_out_host ? {28'h0, out_host_ff} :
                        hit_out_src ? {20'h0, out_src_ff} :
                        hit_level ? {28'h0, level_rd} :
                        hit_stat ? {26'h0, stat_ff} :
                        hit_mask ? {26'h0, mask_ff} :
                        hit_slot ? slot_mem[slot_idx] :
                        hit_judg ? judg_rd : ZERO_W;

   // Bus answer: ack one cycle after the request, data registered with it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ack_ff <= 1'b0;
         dat_ff <= ZERO_W;
      end else if (ce) begin
         ack_ff <= bus_req;
         dat_ff <= bus_req ? rd_mux : dat_ff;
      end
   end

   // Control registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         in_mode_ff <= '0;
         out_mode_ff <= '0;
         out_host_ff <= '0;
         out_src_ff <= '0;
         mask_ff <= '0;
      end else if (ce && wr) begin
         if (hit_in_mode) in_mode_ff <= wdat_in_mode[N-1:0];
         if (hit_out_mode) out_mode_ff <= wdat_out_mode[2*N-1:0];
         if (hit_out_host) out_host_ff <= wdat_out_host[N-1:0];
         if (hit_out_src) out_src_ff <= wdat_out_src[3*N-1:0];
         if (hit_mask) mask_ff <= wdat_mask[rpio_pkg::IRQ_W-1:0];
      end
   end

   // Command slots; contents are opaque here, the processor interprets them
   always_ff @(posedge clk_sys) begin
      if (ce && wr && hit_slot) begin
         slot_mem[slot_idx] <= lane_merge(slot_mem[slot_idx], wb_dat_i, wb_sel_i);
      end
   end

   // Input synchroniser; stage one feeds only stage two
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
      end else if (ce) begin
         sync1_ff <= din;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // Rising edges on trigger-mode inputs only
   wire [N-1:0] trig_edge = sync2_ff & ~sync3_ff & in_mode_ff;
   // Level-mode edges, watched only to show that they launch nothing
   wire [N-1:0] lvl_edge = sync2_ff & ~sync3_ff & ~in_mode_ff;

   // Launch requests: slot 0 startup, slots 1..4 inputs
   wire [rpio_pkg::N_SLOT-1:0] pend_set = {trig_edge, net_connect};
   wire [rpio_pkg::N_SLOT-1:0] pend_pick = (launch_ff.valid || pend_ff == '0) ? '0 :
                                           (pend_ff & (~pend_ff + 5'h01));
   wire [2:0] pick_idx = pend_pick[0] ? 3'h0 : pend_pick[1] ? 3'h1 : pend_pick[2] ? 3'h2 :
                         pend_pick[3] ? 3'h3 : 3'h4;
   // Set wins over the clear of a picked slot
   wire [rpio_pkg::N_SLOT-1:0] nxt_pend = (pend_ff & ~pend_pick) | pend_set;

   // Launch handshake; held until the command processor accepts it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pend_ff <= rpio_pkg::PEND_RST;
         launch_ff <= '0;
      end else if (ce) begin
         pend_ff <= nxt_pend;
         if (launch_ff.valid && cmd_ready) begin
            launch_ff.valid <= 1'b0;
         end else if (pend_pick != '0) begin
            launch_ff.valid <= 1'b1;
            launch_ff.slot <= pick_idx;
            launch_ff.word <= slot_mem[pick_idx];
         end
      end
   end

   // Duration tick counter; free-running, so a pulse may come up to one
   // tick short, traded for one shared counter instead of one per output
   wire tick = tick_cnt_ff == TICK_CYCLES - 1;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tick_cnt_ff <= ZERO_W;
      end else if (ce) begin
         tick_cnt_ff <= tick ? ZERO_W : tick_cnt_ff + 32'h0000_0001;
      end
   end

   // Status sources: run, fault, activity, antennas 1..4
   wire [rpio_pkg::N_SRC-1:0] src_vec = {antenna_select_indicators,
                                         |antenna_select_indicators,
                                         fault_stop, run_state};

   // Per-output judgment and output drive
   logic [N-1:0] jn_fire;
   logic [N-1:0] je_fire;
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_out
         wire [1:0] op = jn_cfg_ff[gi][rpio_pkg::JB_OP +: 2];
         wire [15:0] num = jn_cfg_ff[gi][rpio_pkg::JB_VAL +: 16];
         wire [15:0] cnt = resp.tag_count;
         // Count and data comparisons
         wire cnt_ok = (op == rpio_pkg::OP_GE) ? (cnt >= num) :
                       (op == rpio_pkg::OP_LE) ? (cnt <= num) :
                       (op == rpio_pkg::OP_EQ) ? (cnt == num) : (cnt != num);
         wire dat_ok = op[0] ? (resp.tag_data != jdata_ff[gi]) :
                               (resp.tag_data == jdata_ff[gi]);
         wire cond = jn_cfg_ff[gi][rpio_pkg::JB_DATA] ? dat_ok : cnt_ok;
         wire [2:0] sel = out_src_ff[3*gi +: 3];
         wire src_bit = (sel < 3'(rpio_pkg::N_SRC)) ? src_vec[sel] : 1'b0;
         wire [1:0] mode = out_mode_ff[2*gi +: 2];
         wire judg_on = (jn_cnt_ff[gi] != 16'h0000) || (je_cnt_ff[gi] != 16'h0000);
         wire nxt_dout = (mode == rpio_pkg::OM_HOST) ? out_host_ff[gi] :
                         (mode == rpio_pkg::OM_STAT) ? src_bit :
                         (mode == rpio_pkg::OM_JUDG) ? judg_on : 1'b0;
         // Normal fires only on success, error only on a matching failure
         assign jn_fire[gi] = resp.valid && resp.ok && jn_cfg_ff[gi][rpio_pkg::JB_EN] && cond;
         assign je_fire[gi] = resp.valid && !resp.ok && je_cfg_ff[gi][rpio_pkg::JB_EN] &&
                              (resp.err_code == je_cfg_ff[gi][rpio_pkg::JB_CODE +: 8]);

         // Judgment config and duration timers; a new fire restarts the time
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               jn_cfg_ff[gi] <= ZERO_W;
               jdur_ff[gi] <= ZERO_W;
               je_cfg_ff[gi] <= ZERO_W;
               jdata_ff[gi] <= ZERO_W;
               jn_cnt_ff[gi] <= 16'h0000;
               je_cnt_ff[gi] <= 16'h0000;
               dout_ff[gi] <= 1'b0;
            end else if (ce) begin
               if (wr && hit_judg && j_out == 2'(gi)) begin
                  case (j_word)
                     rpio_pkg::JW_NORM:
                        jn_cfg_ff[gi] <= lane_merge(jn_cfg_ff[gi], wb_dat_i, wb_sel_i);
                     rpio_pkg::JW_DUR: jdur_ff[gi] <= lane_merge(jdur_ff[gi], wb_dat_i, wb_sel_i);
                     rpio_pkg::JW_ERR:
                        je_cfg_ff[gi] <= lane_merge(je_cfg_ff[gi], wb_dat_i, wb_sel_i);
                     default: jdata_ff[gi] <= lane_merge(jdata_ff[gi], wb_dat_i, wb_sel_i);
                  endcase
               end
               if (jn_fire[gi]) jn_cnt_ff[gi] <= jdur_ff[gi][15:0];
               else if (tick && jn_cnt_ff[gi] != 16'h0000)
                  jn_cnt_ff[gi] <= jn_cnt_ff[gi] - 16'h0001;
               if (je_fire[gi]) je_cnt_ff[gi] <= jdur_ff[gi][31:16];
               else if (tick && je_cnt_ff[gi] != 16'h0000)
                  je_cnt_ff[gi] <= je_cnt_ff[gi] - 16'h0001;
               dout_ff[gi] <= nxt_dout;
            end
         end
      end
   endgenerate

   // Sticky status: launches and judgments set, write-one clears, set wins
   wire [rpio_pkg::IRQ_W-1:0] stat_set = {(|jn_fire) || (|je_fire),
                                          launch_ff.valid && cmd_ready ? 5'(5'h01 << launch_ff.slot)
                                                                       : 5'h00};
   wire [rpio_pkg::IRQ_W-1:0] stat_clr = (wr && hit_stat) ? wdat_w1c[rpio_pkg::IRQ_W-1:0] : '0;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stat_ff <= '0;
         irq_ff <= 1'b0;
      end else if (ce) begin
         stat_ff <= (stat_ff & ~stat_clr) | stat_set;
         irq_ff <= |(stat_ff & mask_ff);
      end
   end

   // Outputs straight from flip-flops
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign irq = irq_ff;
   assign dout = dout_ff;
   assign launch = launch_ff;

   // Checks: bus handshake, interrupt, freeze
   a_ack_single_pulse: assert property (ce && ack_ff |=> !ack_ff)
      else $error("ack held longer than one cycle");
   a_irq_follows_mask: assert property (ce |=> irq_ff == $past(|(stat_ff & mask_ff)))
      else $error("interrupt does not follow masked status");
   a_status_set_wins: assert property (ce && stat_set != '0 |=>
      (stat_ff & $past(stat_set)) == $past(stat_set))
      else $error("status event lost to a clear");
   a_freeze_state: assert property (!ce |=>
      $stable(dout_ff) && $stable(stat_ff) && $stable(pend_ff) && $stable(launch_ff))
      else $error("state moved while clock enable low");

   // Checks: inputs and launches
   a_edge_sets_pend: assert property (ce && trig_edge != '0 |=>
      (pend_ff[4:1] & $past(trig_edge)) == $past(trig_edge))
      else $error("trigger edge lost");
   a_level_no_launch: assert property (ce && lvl_edge != '0 |=>
      (pend_ff[4:1] & $past(lvl_edge)) ==
      ($past(pend_ff[4:1] & ~pend_pick[4:1]) & $past(lvl_edge)))
      else $error("level input launched a command");
   a_launch_held: assert property (ce && launch_ff.valid && !cmd_ready |=>
      launch_ff.valid && $stable(launch_ff.word))
      else $error("launch dropped before acceptance");
   a_launch_gap: assert property (ce && launch_ff.valid && cmd_ready |=>
      !launch_ff.valid)
      else $error("no idle cycle after an accepted launch");
   a_connect_startup: assert property (ce && net_connect |=>
      pend_ff[0] || launch_ff.slot == 3'h0)
      else $error("connection did not request startup slot");
   a_sync_two_stage: assert property (ce && $rose(sync2_ff[0]) && in_mode_ff[0] |->
      $past(din[0], 2))
      else $error("input edge seen without two-stage delay");

   // Checks: output sources and judgments
   a_activity_or: assert property (ce && out_mode_ff[1:0] == rpio_pkg::OM_STAT &&
      out_src_ff[2:0] == rpio_pkg::SRC_ACT |=> dout_ff[0] == $past(|antenna_select_indicators))
      else $error("activity output is not antenna OR");
   a_antenna_one: assert property (ce && out_mode_ff[5:4] == rpio_pkg::OM_STAT &&
      out_src_ff[8:6] == 3'(rpio_pkg::SRC_ACT + 1) |=>
      dout_ff[2] == $past(antenna_select_indicators[0]))
      else $error("antenna output does not follow its indicator");
   a_host_output: assert property (ce && out_mode_ff[1:0] == rpio_pkg::OM_HOST |=>
      dout_ff[0] == $past(out_host_ff[0]))
      else $error("host output does not follow host level");
   a_judg_output: assert property (ce && out_mode_ff[1:0] == rpio_pkg::OM_JUDG |=>
      dout_ff[0] == $past(jn_cnt_ff[0] != 16'h0000 || je_cnt_ff[0] != 16'h0000))
      else $error("judgment output does not follow its timers");
   a_normal_load: assert property (ce && jn_fire[0] |=>
      jn_cnt_ff[0] == $past(jdur_ff[0][15:0]))
      else $error("normal judgment duration not loaded");
   a_error_load: assert property (ce && je_fire[0] |=>
      je_cnt_ff[0] == $past(jdur_ff[0][31:16]))
      else $error("error judgment duration not loaded");
endmodule // rpio_core
`default_nettype wire

// ===== rpio_pkg.sv
// Constants, register map and carrier types for the programmable I/O block
package rpio_pkg;
   // Geometry
   localparam int unsigned N_IO = 4;
   localparam int unsigned N_SLOT = 5;
   localparam int unsigned ADR_W = 8;
   // Register byte offsets
   localparam logic [7:0] ADR_IN_MODE = 8'h00;
   localparam logic [7:0] ADR_OUT_MODE = 8'h04;
   localparam logic [7:0] ADR_OUT_HOST = 8'h08;
   localparam logic [7:0] ADR_OUT_SRC = 8'h0C;
   localparam logic [7:0] ADR_IN_LEVEL = 8'h10;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h18;
   // Slot window 0x20..0x30, judgment window 0x40..0x7F
   localparam logic [2:0] SLOT_PAGE = 3'h1;
   localparam logic [1:0] JUDG_PAGE = 2'h1;
   localparam logic [1:0] JW_NORM = 2'h0;
   localparam logic [1:0] JW_DUR = 2'h1;
   localparam logic [1:0] JW_ERR = 2'h2;
   localparam logic [1:0] JW_DATA = 2'h3;
   // Output function per 2-bit field
   localparam logic [1:0] OM_HOST = 2'h0;
   localparam logic [1:0] OM_STAT = 2'h1;
   localparam logic [1:0] OM_JUDG = 2'h2;
   // Status source codes per 3-bit field
   localparam logic [2:0] SRC_RUN = 3'h0;
   localparam logic [2:0] SRC_ERR = 3'h1;
   localparam logic [2:0] SRC_ACT = 3'h2;
   localparam int unsigned N_SRC = 7;
   // Count compare operators
   localparam logic [1:0] OP_GE = 2'h0;
   localparam logic [1:0] OP_LE = 2'h1;
   localparam logic [1:0] OP_EQ = 2'h2;
   // Judgment config fields
   localparam int unsigned JB_EN = 0;
   localparam int unsigned JB_DATA = 1;
   localparam int unsigned JB_OP = 2;
   localparam int unsigned JB_VAL = 16;
   localparam int unsigned JB_CODE = 8;
   // Interrupt status bits: slot launches then judgment fire
   localparam int unsigned IRQ_W = 6;
   localparam int unsigned IB_JUDG = 5;
   // Reset values
   localparam logic [4:0] PEND_RST = 5'h01;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   // Duration unit is one millisecond
   localparam int unsigned CLK_NS = 10;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

   // Completed communication response
   typedef struct packed {
      logic valid;
      logic ok;
      logic [15:0] tag_count;
      logic [31:0] tag_data;
      logic [7:0] err_code;
   } rpio_resp_t;

   // Command launched toward the command processor
   typedef struct packed {
      logic valid;
      logic [2:0] slot;
      logic [31:0] word;
   } rpio_cmd_t;
endpackage

// ===== tb_rpio_core.sv
// Self-checking bench for the programmable I/O and self-operation block
`timescale 1ns/1ps
`default_nettype none
module tb_rpio_core;
   localparam int unsigned TICKS = 4;
   localparam logic [3:0] FIRE_EXP = 4'b1001;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, irq, cmd_ready;
   logic run_state = 1'b0, fault_stop = 1'b0, net_connect = 1'b0, ce = 1'b1;
   logic [3:0] din = 4'h0, ant = 4'h0, stall = 4'h0, dout;
   rpio_pkg::rpio_resp_t resp = '0;
   rpio_pkg::rpio_cmd_t launch;
   logic [2:0] last_slot;
   logic [31:0] last_word;
   logic [7:0] taken;
   int failures = 0, comparisons = 0;

   // Short tick so output durations stay a few cycles long
   rpio_core #(.TICK_CYCLES(TICKS)) uut (
      .clk_sys(clk_sys), .reset(reset), .ce(ce),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .irq(irq), .din(din), .dout(dout), .run_state(run_state), .fault_stop(fault_stop),
      .antenna_select_indicators(ant), .net_connect(net_connect), .resp(resp),
      .cmd_ready(cmd_ready), .launch(launch));

   rpio_cmd_model far (
      .clk_sys(clk_sys), .reset(reset), .launch(launch), .stall(stall),
      .cmd_ready(cmd_ready), .last_slot(last_slot), .last_word(last_word), .taken(taken));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic timeout(input string msg);
      failures++;
      $display("unexpected at %0t: no answer, %s", $time, msg);
      end_of_test();
   endtask

   // One classic cycle; ack and data are taken at the same edge, then released
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (wb_ack_o === 1'b1) break;
      end
      if (n == 20) timeout("bus");
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string msg);
      wb(1'b0, adr, 32'h0000_0000);
      chk(rd, exp, msg);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   // Waits for the processor model to take the next command
   task automatic expect_launch(input logic [2:0] slot, input logic [31:0] word,
                                input logic with_word);
      logic [7:0] t0;
      int n;
      t0 = taken;
      for (n = 0; n < 60; n++) begin
         @(posedge clk_sys);
         if (taken !== t0) break;
      end
      if (n == 60) timeout("launch");
      chk(32'(last_slot), 32'(slot), "launch slot");
      if (with_word) chk(last_word, word, "launch word");
   endtask

   // Completion pulse, then count the cycles output 0 stands high
   task automatic judge(input logic ok, input logic [15:0] cnt, input logic [31:0] data,
                        input logic [7:0] code, output int hi);
      resp <= {1'b1, ok, cnt, data, code};
      @(posedge clk_sys);
      resp.valid <= 1'b0;
      hi = 0;
      repeat (40) begin
         @(posedge clk_sys);
         if (dout[0] === 1'b1) hi++;
      end
   endtask

   initial begin
      int hi;
      int k;
      logic [7:0] t;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      expect_launch(3'h0, 32'h0000_0000, 1'b0);
      stall <= 4'h3;
      // Startup word is a plain command, never a reset
      wb(1'b1, 8'h20, 32'h0000_0A11);
      net_connect <= 1'b1;
      @(posedge clk_sys);
      net_connect <= 1'b0;
      expect_launch(3'h0, 32'h0000_0A11, 1'b1);
      // Level inputs, then all four as triggers rising together
      din <= 4'h5;
      cyc(4);
      rdchk(rpio_pkg::ADR_IN_LEVEL, 32'h0000_0005, "level read");
      din <= 4'h0;
      for (k = 1; k < 5; k++) wb(1'b1, 8'(32'h20 + 4 * k), 32'hC0DE_0000 + k);
      wb(1'b1, rpio_pkg::ADR_IRQ_STAT, 32'h0000_003F);
      wb(1'b1, rpio_pkg::ADR_IN_MODE, 32'h0000_000F);
      din <= 4'hF;
      for (k = 1; k < 5; k++) expect_launch(k[2:0], 32'hC0DE_0000 + k, 1'b1);
      t = taken;
      cyc(30);
      chk(32'(taken), 32'(t), "extra launch");
      rdchk(rpio_pkg::ADR_IN_LEVEL, 32'h0000_0000, "trigger level");
      // Sticky status, mask and level interrupt
      rdchk(rpio_pkg::ADR_IRQ_STAT, 32'h0000_001E, "status");
      chk(32'(irq), 32'h0, "irq masked");
      wb(1'b1, rpio_pkg::ADR_IRQ_MASK, 32'h0000_0004);
      cyc(2);
      chk(32'(irq), 32'h1, "irq raised");
      wb(1'b1, rpio_pkg::ADR_IRQ_STAT, 32'h0000_0004);
      cyc(2);
      chk(32'(irq), 32'h0, "irq cleared");
      rdchk(rpio_pkg::ADR_IRQ_STAT, 32'h0000_001A, "status after clear");
      rdchk(8'h1C, 32'h0000_0000, "unmapped read");
      // Host-driven outputs, then status sources
      wb(1'b1, rpio_pkg::ADR_OUT_MODE, 32'h0000_0000);
      wb(1'b1, rpio_pkg::ADR_OUT_HOST, 32'h0000_000A);
      cyc(2);
      chk(32'(dout), 32'h0000_000A, "host output");
      wb(1'b1, rpio_pkg::ADR_OUT_MODE, 32'h0000_0055);
      wb(1'b1, rpio_pkg::ADR_OUT_SRC, 32'h0000_0888);
      run_state <= 1'b1;
      ant <= 4'h2;
      cyc(3);
      chk(32'(dout), 32'h0000_000D, "status out a");
      // Clock enable low freezes the outputs while the sources move
      ce <= 1'b0;
      run_state <= 1'b0;
      fault_stop <= 1'b1;
      ant <= 4'h1;
      cyc(3);
      chk(32'(dout), 32'h0000_000D, "frozen output");
      ce <= 1'b1;
      cyc(3);
      chk(32'(dout), 32'h0000_0006, "status out b");
      // Activity, antenna four, antenna one, unused code
      wb(1'b1, rpio_pkg::ADR_OUT_SRC, 32'h0000_0EF2);
      cyc(3);
      chk(32'(dout), 32'h0000_0005, "status out c");
      fault_stop <= 1'b0;
      ant <= 4'h0;
      // Judgments on output 0: every count operator, data compare, error code
      wb(1'b1, rpio_pkg::ADR_OUT_MODE, 32'h0000_0056);
      wb(1'b1, 8'h44, 32'h0005_0002);
      wb(1'b1, 8'h48, 32'h0000_5A01);
      for (k = 0; k < 4; k++) begin
         wb(1'b1, 8'h40, {16'h0003, 12'h000, k[1:0], 2'b01});
         judge(1'b1, 16'h0004, 32'h0000_0000, 8'h00, hi);
         chk(32'(hi > 0), 32'(FIRE_EXP[k]), "count judgment");
      end
      chk(32'(hi >= 3 && hi <= 9), 32'h1, "normal duration");
      wb(1'b1, 8'h4C, 32'hCAFE_0001);
      wb(1'b1, 8'h40, 32'h0000_0003);
      judge(1'b1, 16'h0000, 32'hCAFE_0001, 8'h00, hi);
      chk(32'(hi > 0), 32'h1, "data equal");
      judge(1'b1, 16'h0000, 32'hCAFE_0002, 8'h5A, hi);
      chk(32'(hi > 0), 32'h0, "data differ");
      judge(1'b0, 16'h0004, 32'hCAFE_0001, 8'h5A, hi);
      chk(32'(hi >= 15 && hi <= 21), 32'h1, "error duration");
      judge(1'b0, 16'h0004, 32'hCAFE_0001, 8'h5B, hi);
      chk(32'(hi > 0), 32'h0, "other error code");
      end_of_test();
   end
endmodule // tb_rpio_core
`default_nettype wire
